/* File: verilog/slcr_defs.vh */
// constants for the serial link command register block
`ifndef SLCR_DEFS_VH
`define SLCR_DEFS_VH
`define SLCR_CMD_W        16
`define SLCR_BUS_W        32
`define SLCR_NCH          8
`define SLCR_BIT_WRITE    15
`define SLCR_BIT_ROMRST   14
`define SLCR_BIT_REQ      13
`define SLCR_BIT_TRIG     12
`define SLCR_BIT_SS       11
`define SLCR_BIT_IGNORE   31
`define SLCR_TYPE_HI      10
`define SLCR_TYPE_LO      8
`define SLCR_TYPE_STOP    3'h0
`define SLCR_TYPE_NORMAL  3'h1
`define SLCR_TYPE_SETUP   3'h7
`define SLCR_HALT_ALL     16'h0800
`define SLCR_CMD_IDLE     16'h0000
`define SLCR_MASK_NONE    8'h00
`define SLCR_TMO_CYC      16'h0100
`define SLCR_CNT_ZERO     16'h0000
`define SLCR_CNT_ONE      16'h0001
`endif

/* File: verilog/slcr_chan_tracker.v */
// per-channel transfer tracker with timeout
`default_nettype none
module slcr_chan_tracker (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        start,
    input  wire [7:0]  mask,
    input  wire [7:0]  done_in,
    output reg         busy_r,
    output reg  [7:0]  fail_r
);
`include "slcr_defs.vh"
    reg [7:0]  pend_r;
    reg [15:0] cnt_r;
    // track pending channels until all done or timeout
    always @(posedge core_clk) begin
        if (rst) begin
            pend_r <= `SLCR_MASK_NONE;
            cnt_r  <= `SLCR_CNT_ZERO;
            busy_r <= 1'b0;
            fail_r <= `SLCR_MASK_NONE;
        end else if (start) begin
            pend_r <= mask;
            cnt_r  <= `SLCR_TMO_CYC;
            busy_r <= 1'b1;
            fail_r <= `SLCR_MASK_NONE;
        end else if (busy_r) begin
            pend_r <= pend_r & ~done_in;
            cnt_r  <= cnt_r - `SLCR_CNT_ONE;
            if ((pend_r & ~done_in) == `SLCR_MASK_NONE) begin
                busy_r <= 1'b0;
            end else if (cnt_r == `SLCR_CNT_ONE) begin
                busy_r <= 1'b0;
                fail_r <= pend_r & ~done_in;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verilog/slcr_top.v */
// command register and decoder for the serial link processor
//
// Function
// - 16-bit command, low part of 32-bit word
// - bit 15 marks a data write
// - bit 14 resets processor, loads program
// - bit 13 is the request flag
// - bit 12 triggers process-data transfer
// - start/stop type 000 stops masked channels
// - type 001 starts masked channels normally
// - type 111 starts masked channels in setup
// - low eight bits select channels
// - command runs as soon as written
// - register clears to zero when done
// - busy read returns the command in progress; other writes are dropped
// - halt-every-channel accepted even while busy
// - writes with bit 31 high are discarded
// - 0x0800 resets all per-channel variables
// - transfer completes when all done or timed out
`default_nettype none
module slcr_top (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        cmd_wr,
    input  wire [31:0] cmd_wdata,
    output wire [31:0] cmd_rdata,
    input  wire [7:0]  xfer_done,
    input  wire        param_ack,
    output reg  [7:0]  chan_run_r,
    output reg  [7:0]  chan_setup_r,
    output reg         chan_vars_clr_r,
    output reg  [7:0]  xfer_req_r,
    output reg         param_req_r,
    output reg         param_write_r,
    output reg  [12:0] param_addr_r,
    output reg         proc_reset_r,
    output reg         rom_load_r,
    output reg  [7:0]  xfer_fail_r
);
`include "slcr_defs.vh"
    localparam ST_IDLE  = 2'd0;
    localparam ST_EXEC  = 2'd1;
    localparam ST_XFER  = 2'd2;
    localparam ST_PARAM = 2'd3;

    reg  [15:0] link_command_r;
    reg  [1:0]  state_r;
    reg  [7:0]  dsync1_r;
    reg  [7:0]  dsync2_r;
    reg         ack1_r;
    reg         ack2_r;
    reg         trk_start_r;
    wire        trk_busy;
    wire [7:0]  trk_fail;
    wire        accept;
    wire        halt_all;
    wire [7:0]  cmd_mask;
    wire [2:0]  cmd_type;

    // ******************************
    // host register access
    // ******************************

    assign cmd_rdata = {`SLCR_CMD_IDLE, link_command_r};
    assign halt_all = cmd_wr && !cmd_wdata[`SLCR_BIT_IGNORE] &&
                      (cmd_wdata[15:0] == `SLCR_HALT_ALL);
    assign accept   = cmd_wr && !cmd_wdata[`SLCR_BIT_IGNORE];
    // mask and type fields of the stored command
    assign cmd_mask = link_command_r[7:0];
    assign cmd_type = link_command_r[`SLCR_TYPE_HI:`SLCR_TYPE_LO];

    // ******************************
    // input synchronisers
    // ******************************

    // external done and ack pass two flops
    always @(posedge core_clk) begin
        if (rst) begin
            dsync1_r <= `SLCR_MASK_NONE;
            dsync2_r <= `SLCR_MASK_NONE;
            ack1_r   <= 1'b0;
            ack2_r   <= 1'b0;
        end else begin
            dsync1_r <= xfer_done;
            dsync2_r <= dsync1_r;
            ack1_r   <= param_ack;
            ack2_r   <= ack1_r;
        end
    end

    // ******************************
    // command execution
    // ******************************

    // decode and run commands
    always @(posedge core_clk) begin
        if (rst) begin
            link_command_r  <= `SLCR_CMD_IDLE;
            state_r         <= ST_IDLE;
            chan_run_r      <= `SLCR_MASK_NONE;
            chan_setup_r    <= `SLCR_MASK_NONE;
            chan_vars_clr_r <= 1'b0;
            xfer_req_r      <= `SLCR_MASK_NONE;
            param_req_r     <= 1'b0;
            param_write_r   <= 1'b0;
            param_addr_r    <= 13'h0000;
            proc_reset_r    <= 1'b0;
            rom_load_r      <= 1'b0;
            trk_start_r     <= 1'b0;
            xfer_fail_r     <= `SLCR_MASK_NONE;
        end else begin
            chan_vars_clr_r <= 1'b0;
            proc_reset_r    <= 1'b0;
            trk_start_r     <= 1'b0;
            if (halt_all) begin
                link_command_r  <= `SLCR_CMD_IDLE;
                chan_run_r      <= `SLCR_MASK_NONE;
                chan_setup_r    <= `SLCR_MASK_NONE;
                chan_vars_clr_r <= 1'b1;
                xfer_req_r      <= `SLCR_MASK_NONE;
                param_req_r     <= 1'b0;
                state_r         <= ST_IDLE;
            end else if (accept && state_r == ST_IDLE) begin
                link_command_r <= cmd_wdata[15:0];
                state_r        <= ST_EXEC;
            end else begin
                case (state_r)
                    ST_EXEC: begin
                        if (link_command_r[`SLCR_BIT_ROMRST]) begin
                            proc_reset_r <= 1'b1;
                            rom_load_r   <= 1'b1;
                            chan_run_r   <= `SLCR_MASK_NONE;
                            state_r      <= ST_IDLE;
                            link_command_r <= `SLCR_CMD_IDLE;
                        end else if (link_command_r[`SLCR_BIT_REQ]) begin
                            param_req_r   <= 1'b1;
                            param_write_r <=
                                link_command_r[`SLCR_BIT_WRITE];
                            param_addr_r  <= link_command_r[12:0];
                            state_r       <= ST_PARAM;
                        end else if (link_command_r[`SLCR_BIT_TRIG]) begin
                            xfer_req_r  <= cmd_mask;
                            trk_start_r <= 1'b1;
                            state_r     <= ST_XFER;
                        end else begin
                            if (link_command_r[`SLCR_BIT_SS]) begin
                                case (cmd_type)
                                    `SLCR_TYPE_STOP: begin
                                        chan_run_r <= chan_run_r &
                                            ~cmd_mask;
                                        chan_setup_r <= chan_setup_r &
                                            ~cmd_mask;
                                    end
                                    `SLCR_TYPE_NORMAL: begin
                                        chan_run_r <= chan_run_r |
                                            cmd_mask;
                                        chan_setup_r <= chan_setup_r &
                                            ~cmd_mask;
                                    end
                                    `SLCR_TYPE_SETUP: begin
                                        chan_run_r <= chan_run_r |
                                            cmd_mask;
                                        chan_setup_r <= chan_setup_r |
                                            cmd_mask;
                                    end
                                    default: begin
                                        chan_run_r <= chan_run_r;
                                    end
                                endcase
                            end
                            link_command_r <= `SLCR_CMD_IDLE;
                            state_r        <= ST_IDLE;
                        end
                    end
                    ST_XFER: begin
                        // wait for all done or timeout
                        if (!trk_start_r && !trk_busy) begin
                            xfer_req_r     <= `SLCR_MASK_NONE;
                            xfer_fail_r    <= trk_fail;
                            link_command_r <= `SLCR_CMD_IDLE;
                            state_r        <= ST_IDLE;
                        end
                    end
                    ST_PARAM: begin
                        if (ack2_r) begin
                            param_req_r    <= 1'b0;
                            link_command_r <= `SLCR_CMD_IDLE;
                            state_r        <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // transfer completion tracker
    slcr_chan_tracker u_trk (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (trk_start_r),
        .mask     (xfer_req_r),
        .done_in  (dsync2_r),
        .busy_r   (trk_busy),
        .fail_r   (trk_fail)
    );
endmodule
`default_nettype wire

/* File: test/slcr_link_model.sv */
// behavioural model of the remote link channels
`default_nettype none
module slcr_link_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       slow,
    input  wire logic [7:0] mute,
    input  wire logic [7:0] xfer_req,
    input  wire logic       param_req,
    output var  logic [7:0] xfer_done,
    output var  logic       param_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] wait_r;
    // answer after a short or long delay; muted channels never answer
    always_ff @(posedge core_clk) begin
        if (rst || (xfer_req == 8'h00 && !param_req)) begin
            wait_r    <= 8'h00;
            xfer_done <= 8'h00;
            param_ack <= 1'b0;
        end else begin
            wait_r <= wait_r + 8'h01;
            if (wait_r == (slow ? 8'h28 : 8'h03)) begin
                xfer_done <= xfer_req & ~mute;
                param_ack <= param_req;
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/slcr_checker.sv */
// assertion checker for the link command register
`default_nettype none
module slcr_checker (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        cmd_wr,
    input wire logic [31:0] cmd_wdata,
    input wire logic [31:0] cmd_rdata,
    input wire logic [7:0]  chan_run_r,
    input wire logic [7:0]  chan_setup_r,
    input wire logic        chan_vars_clr_r,
    input wire logic [7:0]  xfer_req_r,
    input wire logic        proc_reset_r,
    input wire logic        rom_load_r
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [7:0] mask_r;
    wire logic  take = cmd_wr && !cmd_wdata[31] && cmd_rdata == 32'h0;
    // channel mask of the last accepted command
    always_ff @(posedge core_clk) begin
        if (take) mask_r <= cmd_wdata[7:0];
    end
    upper_zero_a: assert property (cmd_rdata[31:16] == 16'h0000)
        else $error("upper half nonzero");
    take_cmd_a: assert property (take && cmd_wdata[15:0] != 16'h0800
        |=> cmd_rdata == {16'h0000, $past(cmd_wdata[15:0])})
        else $error("command not taken");
    start_norm_a: assert property (take && cmd_wdata[15:8] == 8'h09
        |-> ##[1:3] cmd_rdata == 0 && (chan_run_r & mask_r) == mask_r)
        else $error("normal start failed");
    start_setup_a: assert property (take && cmd_wdata[15:8] == 8'h0f
        |-> ##[1:3] cmd_rdata == 0 && (chan_setup_r & mask_r) == mask_r)
        else $error("setup start failed");
    stop_chan_a: assert property (take && cmd_wdata[15:8] == 8'h08
        && cmd_wdata[7:0] != 0 |-> ##[1:3] (chan_run_r & mask_r) == 0)
        else $error("channel stop failed");
    halt_all_a: assert property (cmd_wr && !cmd_wdata[31]
        && cmd_wdata[15:0] == 16'h0800 |-> ##[1:2]
        chan_vars_clr_r && cmd_rdata == 0 && chan_run_r == 0)
        else $error("halt not honoured");
    clr_cause_a: assert property ($rose(chan_vars_clr_r) |->
        $past(cmd_wr) && $past(cmd_wdata[15:0]) == 16'h0800)
        else $error("variable clear without halt");
    rom_reset_a: assert property (take && cmd_wdata[14]
        |-> ##[1:3] proc_reset_r && rom_load_r)
        else $error("processor reset missing");
    trig_mask_a: assert property (take && cmd_wdata[15:12] == 4'h1
        |-> ##[1:3] xfer_req_r == mask_r)
        else $error("transfer mask wrong");
    trig_end_a: assert property ($rose(xfer_req_r != 8'h00)
        |-> ##[1:300] cmd_rdata == 0)
        else $error("transfer never completed");
    ignore_bit_a: assert property (cmd_wr && cmd_wdata[31]
        && cmd_rdata == 0 |=> cmd_rdata == 0)
        else $error("ignored write took effect");
endmodule
bind slcr_top slcr_checker u_chk (.core_clk, .rst, .cmd_wr, .cmd_wdata,
    .cmd_rdata, .chan_run_r, .chan_setup_r, .chan_vars_clr_r, .xfer_req_r,
    .proc_reset_r, .rom_load_r);
`default_nettype wire

/* File: test/tb_slcr_top.sv */
// self-checking testbench for the link command register
`default_nettype none
module tb_slcr_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk, rst, cmd_wr, slow, param_ack, chan_vars_clr_r;
    logic        param_req_r, param_write_r, proc_reset_r, rom_load_r;
    logic [31:0] cmd_wdata, cmd_rdata;
    logic [7:0]  mute, xfer_done, chan_run_r, chan_setup_r, xfer_req_r;
    logic [7:0]  xfer_fail_r, keep;
    logic [12:0] param_addr_r;
    int          fail_count, num_checks, cycles;
    slcr_top dut (.core_clk, .rst, .cmd_wr, .cmd_wdata, .cmd_rdata,
        .xfer_done, .param_ack, .chan_run_r, .chan_setup_r,
        .chan_vars_clr_r, .xfer_req_r, .param_req_r, .param_write_r,
        .param_addr_r, .proc_reset_r, .rom_load_r, .xfer_fail_r);
    slcr_link_model link (.core_clk, .rst, .slow, .mute,
        .xfer_req(xfer_req_r), .param_req(param_req_r), .xfer_done,
        .param_ack);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] w);
        @(posedge core_clk);
        cmd_wr    <= 1'b1;
        cmd_wdata <= w;
        @(posedge core_clk);
        cmd_wr    <= 1'b0;
        #1;
    endtask
    // poll until the register reads zero, bounded
    task automatic idle(input int n);
        int i;
        i = 0;
        while (cmd_rdata !== 32'h0 && i < n) begin
            @(posedge core_clk);
            #1;
            i++;
        end
        chk(cmd_rdata, 32'h0);
    endtask
    task automatic t_modes;
        wr(32'h0000_0800);
        idle(3);
        chk(32'(chan_vars_clr_r), 32'h1);
        wr(32'h0000_0903);
        chk(cmd_rdata, 32'h0000_0903);
        idle(4);
        chk(32'(chan_run_r), 32'h03);
        wr(32'h0000_0f30);
        idle(4);
        chk(32'(chan_setup_r & 8'h30), 32'h30);
        wr(32'h0000_0802);
        idle(4);
        chk(32'(chan_run_r & 8'h03), 32'h01);
        keep = chan_run_r;
        wr(32'h0000_0a01);
        idle(4);
        chk(32'(chan_run_r), 32'(keep));
        $display("modes test done");
    endtask
    task automatic t_busy;
        wr(32'h8000_0902);
        @(posedge core_clk);
        #1;
        chk(cmd_rdata, 32'h0);
        chk(32'(chan_run_r), 32'h31);
        slow <= 1'b1;
        wr(32'h0000_1003);
        wr(32'h0000_0905);
        chk(cmd_rdata, 32'h0000_1003);
        wr(32'h8000_0000);
        chk(cmd_rdata, 32'h0000_1003);
        idle(100);
        chk(32'(xfer_fail_r), 32'h0);
        chk(32'(chan_run_r), 32'h31);
        wr(32'h0000_1001);
        wr(32'h0000_0800);
        idle(2);
        chk(32'(xfer_req_r), 32'h0);
        chk(32'(chan_run_r), 32'h0);
        slow <= 1'b0;
        $display("busy test done");
    endtask
    task automatic t_timeout;
        mute <= 8'h04;
        wr(32'h0000_1006);
        @(posedge core_clk);
        #1;
        chk(32'(xfer_req_r), 32'h06);
        idle(300);
        chk(32'(xfer_fail_r), 32'h04);
        mute <= 8'h00;
        $display("timeout test done");
    endtask
    task automatic t_param;
        wr(32'h0000_a005);
        @(posedge core_clk);
        #1;
        chk({param_req_r, param_write_r, 17'h0, param_addr_r},
            {2'b11, 30'h0005});
        idle(20);
        wr(32'h0000_2007);
        @(posedge core_clk);
        #1;
        chk({param_req_r, param_write_r, 17'h0, param_addr_r},
            {2'b10, 30'h0007});
        idle(20);
        wr(32'h0000_4000);
        idle(10);
        chk(32'(proc_reset_r), 32'h1);
        chk(32'(rom_load_r), 32'h1);
        $display("param test done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // cut a hang short
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            close_out;
        end
    end
    initial begin
        rst = 1'b1;
        cmd_wr = 1'b0;
        cmd_wdata = 32'h0;
        slow = 1'b0;
        mute = 8'h00;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        t_modes;
        t_busy;
        t_timeout;
        t_param;
        close_out;
    end
endmodule
`default_nettype wire
